// ---- hw/acr_regs.svh ----
/*
 Constants of the converter configuration bank: register offsets, reset values,
 serial word layout and reset timing. Assumes a 10 MHz system clock.
*/
// Operation
// RL1 - Reset held 2 us restores register defaults; the device needs 21 clocks (2.1 us) of reset before it does
// RL2 - Reset also clears core and data outputs
// RL3 - Registers programmed over three serial wires
// RL4 - Without reset pin, host loads defaults serially
// RL5 - Default order: 9,A,B,C,D,E,0,1,F
// RL6 - Word: top nibble address, twelve bits data
// RL7 - Address E gets 804, others zero
// RL8 - Delay loop on by default, bypass below 60MSPS
// RL9 - Host writes nothing until reset ends
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

`define ACR_ADDR_0 4'h0
`define ACR_ADDR_1 4'h1
`define ACR_ADDR_9 4'h9
`define ACR_ADDR_A 4'ha
`define ACR_ADDR_B 4'hb
`define ACR_ADDR_C 4'hc
`define ACR_ADDR_D 4'hd
`define ACR_ADDR_E 4'he
`define ACR_ADDR_F 4'hf
`define ACR_RST_DEFAULT 12'h000
`define ACR_RST_E 12'h804
`define ACR_ADDR_MSB 15
`define ACR_ADDR_LSB 12
`define ACR_DATA_MSB 11
`define ACR_DLL_OFF_BIT 0
`define ACR_WORD_BITS 16
`define ACR_CLK_HZ 10000000
`define ACR_RST_MIN_NS 2000
`define ACR_RST_MIN_CYC ((`ACR_RST_MIN_NS * (`ACR_CLK_HZ / 1000000) + 999) / 1000)
`define ACR_SCLK_HALF 2

`endif

// ---- hw/acr_pkg.sv ----
/*
 Types shared by the host and device ends of the configuration bank.
 Assumes acr_regs.svh supplies the constants.
*/
package acr_pkg;
	typedef logic [11:0] acr_data_t;
	typedef logic [3:0] acr_addr_t;
	typedef enum logic [1:0] {ACR_IDLE, ACR_RESET, ACR_LOAD, ACR_SHIFT} acr_host_e;
endpackage

// ---- hw/acr_if.sv ----
/*
 Three-wire serial link plus the reset line between host and converter.
 Assumes both ends run on the same clk.
*/
`timescale 1ns/1ns
interface acr_if;
	logic sclk;
	logic sen_n;
	logic sdata;
	logic reset;
	modport host (output sclk, output sen_n, output sdata, output reset);
	modport dev (input sclk, input sen_n, input sdata, input reset);
endinterface

// ---- hw/acr_dev.sv ----
/*
 Converter end of the configuration bank: nine write-only configuration
 registers loaded by 16-bit serial words, a reset pulse that restores their
 defaults and holds the converter core, and the registered data outputs.
 Assumes the link pins come from outside the clock domain, so each passes two
 flip-flops first, and that the host sends no word while reset is high.
 A reset pulse shorter than the minimum length leaves the registers alone.
*/

`timescale 1ns/1ns
`include "acr_regs.svh"

module acr_dev
	import acr_pkg::*;
#(
	parameter int DATA_W = 14
) (
	// System
	input wire logic clk,
	input wire logic rst,

	// Link
	acr_if.dev lnk,

	// Converter core
	input wire logic [DATA_W-1:0] sample,
	output logic [DATA_W-1:0] data_out,
	output logic dll_on,
	output logic [12*9-1:0] cfg_flat
);

	typedef struct packed {
		// Pin synchronisers
		logic [2:0] sclk_s;
		logic [1:0] sen_s;
		logic [1:0] sd_s;
		logic [1:0] rst_s;
		// Serial word
		logic [15:0] shreg;
		logic [4:0] cnt;
		// Reset pulse and core
		logic [7:0] rcnt;
		logic core_rst;
		// Registers and data
		acr_data_t [8:0] cfg;
		logic [DATA_W-1:0] dout;
	} acr_dev_s;
	acr_dev_s st_r, st_nxt;

	// Reset pulse length in clocks, counted after the synchroniser
	localparam int RCYC = `ACR_RST_MIN_CYC;
	localparam int NREG = 9;

	// Register map, in the slot order of cfg_flat
	localparam acr_addr_t REG_ADDR [NREG] = '{
		`ACR_ADDR_0,
		`ACR_ADDR_1,
		`ACR_ADDR_9,
		`ACR_ADDR_A,
		`ACR_ADDR_B,
		`ACR_ADDR_C,
		`ACR_ADDR_D,
		`ACR_ADDR_E,
		`ACR_ADDR_F
	};

	// Contents restored by a long enough reset pulse
	localparam acr_data_t REG_RST [NREG] = '{
		`ACR_RST_DEFAULT,
		`ACR_RST_DEFAULT,
		`ACR_RST_DEFAULT,
		`ACR_RST_DEFAULT,
		`ACR_RST_DEFAULT,
		`ACR_RST_DEFAULT,
		`ACR_RST_DEFAULT,
		`ACR_RST_E, // RL7
		`ACR_RST_DEFAULT
	};

	// Serial side
	logic sclk_rise;
	logic frame_on;
	logic word_done;
	acr_addr_t word_addr;
	acr_data_t word_data;
	logic [NREG-1:0] slot_hit;

	// Reset side
	logic rst_seen;
	logic rst_long;

	// Output side
	logic dll_off;

	// Also the asynchronous reset value, so it must stay constant
	function automatic acr_data_t [NREG-1:0] defaults();
		acr_data_t [NREG-1:0] d;
		for (int i = 0; i < NREG; i++) begin
			d[i] = REG_RST[i];
		end
		return d;
	endfunction

	// Shift count: cleared outside a frame and after a whole word
	function automatic logic [4:0] cnt_next(input logic on, input logic rise, input logic done,
			input logic [4:0] cur);
		logic [4:0] n;
		n = cur;
		if (!on || done) begin
			n = 5'h00;
		end else if (rise) begin
			n = cur + 5'h01;
		end
		return n;
	endfunction

	// Pulse counter stops at the minimum length until reset falls
	function automatic logic [7:0] rcnt_next(input logic seen, input logic [7:0] cur);
		logic [7:0] n;
		n = 8'h00;
		if (seen && cur != 8'(RCYC)) begin
			n = cur + 8'h01;
		end else if (seen) begin
			n = cur;
		end
		return n;
	endfunction

	// Edge found on the second stage against the third; the first stage feeds nothing else
	assign sclk_rise = st_r.sclk_s[1] && !st_r.sclk_s[2]; // RL3
	assign frame_on = !st_r.sen_s[1];
	// The sixteenth rising edge completes a word
	assign word_done = frame_on && sclk_rise && st_r.cnt == 5'(`ACR_WORD_BITS - 1);
	// Fifteen bits are in the shift register, the last one on the pin stage
	assign word_addr = st_r.shreg[14:11]; // RL6
	assign word_data = {st_r.shreg[10:0], st_r.sd_s[1]}; // RL6
	assign rst_seen = st_r.rst_s[1];
	// Shorter pulses are ignored so glitches keep the setup
	assign rst_long = rst_seen && st_r.rcnt == 8'(RCYC); // RL1
	// Bypass takes a write; the delay loop runs after rst or a reset pulse long enough to restore defaults
	assign dll_off = st_nxt.cfg[7][`ACR_DLL_OFF_BIT]; // RL8

	// One comparator per register; an unmapped address hits none and is dropped
	for (genvar g = 0; g < NREG; g++) begin : g_slot
		assign slot_hit[g] = word_done && word_addr == REG_ADDR[g]; // RL6
	end

	always_comb begin
		st_nxt = st_r;

		// Link pins through two stages, sclk through a third for the edge
		st_nxt.sclk_s = {st_r.sclk_s[1:0], lnk.sclk};
		st_nxt.sen_s = {st_r.sen_s[0], lnk.sen_n};
		st_nxt.sd_s = {st_r.sd_s[0], lnk.sdata};
		st_nxt.rst_s = {st_r.rst_s[0], lnk.reset};

		// Shift in on each rising serial clock inside a frame
		st_nxt.cnt = cnt_next(frame_on, sclk_rise, word_done, st_r.cnt);
		if (frame_on && sclk_rise) begin
			st_nxt.shreg = {st_r.shreg[14:0], st_r.sd_s[1]};
		end

		// Register writes
		for (int i = 0; i < NREG; i++) begin
			if (slot_hit[i]) begin
				st_nxt.cfg[i] = word_data;
			end
		end

		// Reset pulse: defaults and the core held once it is long enough
		st_nxt.rcnt = rcnt_next(rst_seen, st_r.rcnt);
		st_nxt.core_rst = rst_long; // RL2
		if (rst_long) begin
			st_nxt.cfg = defaults(); // RL1
			st_nxt.shreg = 16'h0000;
			st_nxt.cnt = 5'h00;
		end

		// Data outputs low for as long as the core is held
		if (st_nxt.core_rst) begin
			st_nxt.dout = '0; // RL2
		end else begin
			st_nxt.dout = sample;
		end
	end

	// All state but the outputs in one register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '{cfg: defaults(), default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out <= '0;
			dll_on <= 1'b1;
			cfg_flat <= defaults();
		end else begin
			// Data outputs follow the core one clock late
			data_out <= st_nxt.dout;
			dll_on <= !dll_off; // RL8
			// All nine registers side by side for the surroundings
			cfg_flat <= st_nxt.cfg;
		end
	end
endmodule

// ---- hw/acr_host.sv ----
/*
 Host end: pulses reset or loads the default sequence, then forwards user words
 over the three-wire link.
 Assumes the converter samples on rising sclk while sen_n is low.
*/
`timescale 1ns/1ns
`include "acr_regs.svh"
module acr_host
	import acr_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic rst,
	// Link
	acr_if.host lnk,
	// User
	input wire logic use_hw_reset,
	input wire logic init_req,
	input wire logic wr_req,
	input wire logic [15:0] wr_word,
	output logic busy
);
	typedef struct packed {
		acr_host_e state;
		logic [15:0] word;
		logic [4:0] bit_n;
		logic [3:0] seq;
		logic [7:0] tmr;
		logic loading;
		logic sclk;
		logic sen_n;
		logic sdata;
		logic reset;
	} acr_host_s;
	acr_host_s st_r, st_nxt;
	localparam int RHOLD = `ACR_RST_MIN_CYC + 4;
	function automatic logic [15:0] seq_word(input logic [3:0] i);
		case (i) // RL5
			4'h0: seq_word = {`ACR_ADDR_9, `ACR_RST_DEFAULT};
			4'h1: seq_word = {`ACR_ADDR_A, `ACR_RST_DEFAULT};
			4'h2: seq_word = {`ACR_ADDR_B, `ACR_RST_DEFAULT};
			4'h3: seq_word = {`ACR_ADDR_C, `ACR_RST_DEFAULT};
			4'h4: seq_word = {`ACR_ADDR_D, `ACR_RST_DEFAULT};
			4'h5: seq_word = {`ACR_ADDR_E, `ACR_RST_E}; // RL7
			4'h6: seq_word = {`ACR_ADDR_0, `ACR_RST_DEFAULT};
			4'h7: seq_word = {`ACR_ADDR_1, `ACR_RST_DEFAULT};
			default: seq_word = {`ACR_ADDR_F, `ACR_RST_DEFAULT};
		endcase
	endfunction
	always_comb begin
		logic [15:0] sw;
		sw = seq_word(st_r.seq);
		st_nxt = st_r;
		case (st_r.state)
			ACR_IDLE: begin
				if (init_req && use_hw_reset) begin
					st_nxt.state = ACR_RESET;
					st_nxt.reset = 1'b1; // RL1
					st_nxt.tmr = 8'h00;
				end else if (init_req) begin
					st_nxt.state = ACR_LOAD; // RL4
					st_nxt.seq = 4'h0;
					st_nxt.loading = 1'b1;
				end else if (wr_req) begin
					st_nxt.state = ACR_SHIFT;
					st_nxt.word = wr_word; // RL8
					st_nxt.loading = 1'b0;
					st_nxt.bit_n = 5'h00;
					st_nxt.tmr = 8'h00;
					st_nxt.sen_n = 1'b0;
					st_nxt.sdata = wr_word[15];
				end
			end
			ACR_RESET: begin
				st_nxt.tmr = st_r.tmr + 8'h01;
				// Extra cycles cover the converter's input synchroniser
				if (st_r.tmr == 8'(RHOLD))
					st_nxt.reset = 1'b0;
				if (st_r.tmr == 8'(RHOLD + 4))
					st_nxt.state = ACR_IDLE; // RL9
			end
			ACR_LOAD: begin
				st_nxt.reset = 1'b0; // RL4
				if (st_r.seq == 4'h9) begin
					st_nxt.state = ACR_IDLE;
					st_nxt.loading = 1'b0;
				end else begin
					st_nxt.state = ACR_SHIFT;
					st_nxt.word = sw;
					st_nxt.sdata = sw[15];
					st_nxt.bit_n = 5'h00;
					st_nxt.tmr = 8'h00;
					st_nxt.sen_n = 1'b0;
				end
			end
			ACR_SHIFT: begin // RL3
				st_nxt.tmr = st_r.tmr + 8'h01;
				if (st_r.tmr == 8'(`ACR_SCLK_HALF - 1)) begin
					st_nxt.tmr = 8'h00;
					st_nxt.sclk = !st_r.sclk;
					if (st_r.sclk) begin
						st_nxt.bit_n = st_r.bit_n + 5'h01;
						st_nxt.word = {st_r.word[14:0], 1'b0}; // RL6
						st_nxt.sdata = st_r.word[14];
						if (st_r.bit_n == 5'(`ACR_WORD_BITS - 1)) begin
							st_nxt.sen_n = 1'b1;
							st_nxt.sdata = 1'b0;
							st_nxt.seq = st_r.seq + 4'h1;
							st_nxt.state = st_r.loading ? ACR_LOAD : ACR_IDLE;
						end
					end
				end
			end
			default: st_nxt.state = ACR_IDLE;
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '{state: ACR_IDLE, sen_n: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
		end else begin
			busy <= st_nxt.state != ACR_IDLE;
		end
	end
	assign lnk.sclk = st_r.sclk;
	assign lnk.sen_n = st_r.sen_n;
	assign lnk.sdata = st_r.sdata;
	assign lnk.reset = st_r.reset;
endmodule

// ---- verification/acr_monitor.sv ----
/*
 Link checker for the configuration bank.
 Assumes link, busy and core outputs share clk.
*/
`timescale 1ns/1ns
module acr_monitor (
	// System
	input wire logic clk,
	input wire logic rst,
	// Link
	input wire logic sclk,
	input wire logic sen_n,
	input wire logic sdata,
	input wire logic reset,
	// Ends
	input wire logic busy,
	input wire logic [13:0] data_out,
	input wire logic dll_on
);
	logic [5:0] rcnt_r;
	logic [4:0] bits_r;
	logic sclk_q_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rcnt_r <= '0;
			bits_r <= '0;
			sclk_q_r <= 1'b0;
		end else begin
			rcnt_r <= reset ? rcnt_r + 6'h1 : 6'h0;
			bits_r <= sen_n ? 5'h0 : bits_r + 5'(sclk && !sclk_q_r);
			sclk_q_r <= sclk;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_word_len: assert property ($rose(sen_n) |-> bits_r == 5'd16)
		else $error("frame bit count wrong");
	chk_data_hold: assert property (!sen_n && sclk && $past(sclk) |-> $stable(sdata))
		else $error("data moved while clock high");
	chk_reset_len: assert property ($fell(reset) |-> rcnt_r == 6'd25)
		else $error("reset pulse length wrong");
	chk_out_low: assert property ($fell(reset) |-> data_out == 14'h0)
		else $error("data outputs not low in reset");
	chk_dll_dflt: assert property ($fell(reset) |-> dll_on)
		else $error("delay loop off after reset");
	chk_quiet_reset: assert property (reset |-> sen_n)
		else $error("frame during reset");
	chk_sclk_half: assert property ($rose(sclk) |=> sclk ##1 !sclk)
		else $error("serial clock half period wrong");
	chk_sclk_idle: assert property (sen_n [*4] |-> $stable(sclk))
		else $error("serial clock moves outside frame");
	chk_busy_frame: assert property (!sen_n |-> busy)
		else $error("frame without busy");
endmodule

// ---- verification/tb_top.sv ----
/*
 Bench joining host and converter ends over the link.
 Assumes a 10 MHz clk and default parameters.
*/
`timescale 1ns/1ns
module tb_top;
	logic clk, rst, use_hw_reset, init_req, wr_req, busy, dll_on;
	logic [15:0] wr_word, sh;
	logic [13:0] sample, data_out;
	logic [107:0] cfg_flat, dflt;
	logic [15:0] q[$];
	int n_mismatch, n_checks, sw_rst;
	acr_if lnk();
	acr_host acr_host_i(.clk(clk), .rst(rst), .lnk(lnk), .use_hw_reset(use_hw_reset), .init_req(init_req),
		.wr_req(wr_req), .wr_word(wr_word), .busy(busy));
	acr_dev acr_dev_i(.clk(clk), .rst(rst), .lnk(lnk), .sample(sample), .data_out(data_out), .dll_on(dll_on),
		.cfg_flat(cfg_flat));
	acr_monitor acr_monitor_i(.clk(clk), .rst(rst), .sclk(lnk.sclk), .sen_n(lnk.sen_n), .sdata(lnk.sdata),
		.reset(lnk.reset), .busy(busy), .data_out(data_out), .dll_on(dll_on));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// Words are rebuilt from the wire, not from the host's request
	always @(posedge lnk.sclk) if (!lnk.sen_n) sh <= {sh[14:0], lnk.sdata};
	always @(posedge lnk.sen_n) q.push_back(sh);
	always @(posedge clk) if (lnk.reset === 1'b1 && !use_hw_reset) sw_rst++;
	task automatic cmp(input logic [107:0] got, input logic [107:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("mismatches=%0d checks=%0d", n_mismatch, n_checks);
		if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic go(input logic ini, input logic [15:0] w);
		int i;
		@(posedge clk);
		#1 init_req = ini;
		wr_req = !ini;
		wr_word = w;
		@(posedge clk);
		#1 init_req = 0;
		wr_req = 0;
		for (i = 0; i < 3000 && busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 3000) begin
			n_mismatch++;
			finish_test();
		end
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic hw_init();
		go(0, 16'ha123);
		cmp(cfg_flat, dflt | (108'h123 << 36));
		use_hw_reset = 1;
		go(1, 16'h0);
		cmp(cfg_flat, dflt);
		cmp(dll_on, 108'h1);
		cmp(data_out, sample);
	endtask
	task automatic sw_init();
		logic [15:0] seq [9] = '{16'h9000, 16'ha000, 16'hb000, 16'hc000, 16'hd000, 16'he804, 16'h0000,
			16'h1000, 16'hf000};
		go(0, 16'he001);
		cmp(dll_on, 108'h0);
		use_hw_reset = 0;
		q.delete();
		go(1, 16'h0);
		cmp(q.size(), 108'd9);
		for (int k = 0; k < 9 && k < q.size(); k++) cmp(q[k], seq[k]);
		cmp(sw_rst, 108'h0);
		cmp(cfg_flat, dflt);
	endtask
	task automatic single_writes();
		// Unmapped address must leave every register alone
		go(0, 16'h5abc);
		cmp(cfg_flat, dflt);
		go(0, 16'hf7ff);
		cmp(cfg_flat, dflt | (108'h7ff << 96));
	endtask
	initial begin
		rst = 1;
		use_hw_reset = 0;
		init_req = 0;
		wr_req = 0;
		wr_word = 0;
		sample = 14'h2a5b;
		n_mismatch = 0;
		n_checks = 0;
		sw_rst = 0;
		dflt = {12'h000, 12'h804, 84'h0};
		repeat (2) @(posedge clk);
		#1 rst = 0;
		hw_init();
		sw_init();
		single_writes();
		finish_test();
	end
endmodule
